// ### hw/control_exec.sv
// Purpose: Control section: phase clock, timing chain, sequencer, opcode decode and execution.
// Assumes: Memory answers on the same clock with a valid/ack handshake.
// Notes: Panel controls and visible state are reached over a classic Wishbone slave.
`timescale 1ns/10ps
`default_nettype none
module control_exec #(
  parameter int unsigned TB_PERIOD = ctl_pkg::TB_PERIOD_CYC,
  parameter int unsigned PHASE_DIV = ctl_pkg::PHASE_CYC
) (
  input wire logic core_clk, // Core clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output ctl_pkg::mem_req_t mem_req, // Memory request fields.
  output logic mem_valid, // Memory request valid.
  input wire logic mem_ack, // Memory answer strobe.
  input wire logic [23:0] mem_rdata, // Memory read data.
  output ctl_pkg::ext_fn_t ext_fn, // External function unit and code.
  output logic ext_fn_valid, // External function strobe.
  input wire logic prn_data_req, // Printer controller data request pin.
  input wire logic other_req, // Lower priority service request.
  output logic other_grant, // Grant to lower priority request.
  output logic [3:0] phase, // One-hot master clock phase.
  output logic fault_lamp, // Fault indicator.
  output logic horn, // Horn drive.
  output logic tb_armed // Time-base interrupt armed.
);
  ctl_pkg::seq_t seq;
  ctl_pkg::seq_t next_seq;
  logic [1:0] mode;
  logic halt_byp, horn_dis, running;
  logic [23:0] acc, z, mdr;
  logic [13:0] breg, preg;
  logic [4:0] opcode;
  logic [31:0] div_cnt, tb_cnt;
  logic [1:0] ph;
  logic [2:0] ccyc;
  logic tb_pending, prn_s1, prn_s2, prn_pending, stop_req;

  // Register bus decode.
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire bus_wr = bus_req && wb_we_i && !wb_ack_o && wb_sel_i[0];
  wire wr_ctrl = bus_wr && wb_adr_i == ctl_pkg::REG_CTRL;
  wire wr_p = bus_wr && wb_adr_i == ctl_pkg::REG_PREG && !running;
  wire mclr = wr_ctrl && wb_sel_i[1] && wb_dat_i[ctl_pkg::CTRL_MCLR];
  wire start = wr_ctrl && wb_sel_i[1] && wb_dat_i[ctl_pkg::CTRL_START];
  wire stop = wr_ctrl && wb_sel_i[1] && wb_dat_i[ctl_pkg::CTRL_STOP];
  wire step = wr_ctrl && wb_sel_i[1] && wb_dat_i[ctl_pkg::CTRL_STEP];
  wire [31:0] status = {18'h00000, seq_code(seq), opcode, prn_pending,
    tb_pending, horn, fault_lamp, tb_armed, running};
  wire [31:0] rd_mux =
    (wb_adr_i == ctl_pkg::REG_CTRL) ? {28'h0000000, horn_dis, halt_byp, mode} :
    (wb_adr_i == ctl_pkg::REG_STATUS) ? status :
    (wb_adr_i == ctl_pkg::REG_ACC) ? {8'h00, acc} :
    (wb_adr_i == ctl_pkg::REG_BREG) ? {18'h00000, breg} :
    (wb_adr_i == ctl_pkg::REG_PREG) ? {18'h00000, preg} : 32'h00000000;

  function automatic logic [2:0] seq_code(input ctl_pkg::seq_t s);
    case (s)
      ctl_pkg::SEQ_IDLE: seq_code = 3'h0;
      ctl_pkg::SEQ_FETCH: seq_code = 3'h1;
      ctl_pkg::SEQ_EXEC: seq_code = 3'h2;
      ctl_pkg::SEQ_OPREAD: seq_code = 3'h3;
      ctl_pkg::SEQ_OPWRITE: seq_code = 3'h4;
      ctl_pkg::SEQ_TB_READ: seq_code = 3'h5;
      ctl_pkg::SEQ_TB_WRITE: seq_code = 3'h6;
      default: seq_code = 3'h7;
    endcase
  endfunction

  function automatic logic is_halt(input logic [4:0] op);
    is_halt = op == ctl_pkg::OP_HALT0 || op == ctl_pkg::OP_HALT1 || op == ctl_pkg::OP_STOP;
  endfunction

  // Master clock: phase ticks from a divider, or from the panel step in phase-step mode.
  wire div_tick = div_cnt == PHASE_DIV - 1;
  wire ph_tick = running && ((mode == ctl_pkg::MODE_PHASE_STEP) ? step : div_tick);
  wire last_ph = ph == 2'(ctl_pkg::PHASES - 1) && ccyc == 3'(ctl_pkg::CLK_CYCLES_PER_MEM - 1);
  wire ph_adv = ph_tick && !(last_ph && mem_valid);
  wire mc_end = ph_adv && last_ph;

  // Instruction decode and execution terms.
  wire [4:0] op_new = mdr[23:19];
  wire ex_halt = seq == ctl_pkg::SEQ_EXEC && is_halt(opcode);
  wire ex_ext_fn = seq == ctl_pkg::SEQ_EXEC && opcode == ctl_pkg::OP_EXT_FN;
  wire [4:0] ext_fn_unit = z[18:14];
  wire [10:0] ext_fn_code = z[10:0];
  wire tb_arm = ext_fn_unit == ctl_pkg::UNIT_TBI && ext_fn_code[7:6] == 2'b11;
  wire tb_disarm = ext_fn_unit == ctl_pkg::UNIT_TBI && ext_fn_code[7:5] == 3'b101;
  wire prn_desel = ext_fn_unit == ctl_pkg::UNIT_PRN &&
    ext_fn_code[7:0] == ctl_pkg::PRN_DESELECT;
  wire ext_fn_send = ex_ext_fn && ext_fn_unit != ctl_pkg::UNIT_TBI &&
    !(prn_desel && !prn_pending);
  wire [23:0] b_ext = {{10{breg[13]}}, breg};
  wire [23:0] addb_sum = acc + b_ext;
  wire [9:0] tally = mdr[23:14];
  wire [23:0] acm_sum = mdr + {19'h00000, z[18:14]};
  wire boundary_stop = stop_req || stop || mode != ctl_pkg::MODE_RUN || (ex_halt && !halt_byp);
  wire at_boundary = mc_end && (seq == ctl_pkg::SEQ_EXEC || seq == ctl_pkg::SEQ_OPWRITE ||
    seq == ctl_pkg::SEQ_TB_WRITE || seq == ctl_pkg::SEQ_TB_SAVE);
  wire tb_hit = tb_cnt == TB_PERIOD - 1;

  // Next-sequence choice.
  always_comb begin
    case (seq)
      ctl_pkg::SEQ_FETCH: next_seq = (op_new == ctl_pkg::OP_ACM) ? ctl_pkg::SEQ_OPREAD :
        ctl_pkg::SEQ_EXEC;
      ctl_pkg::SEQ_OPREAD: next_seq = ctl_pkg::SEQ_OPWRITE;
      ctl_pkg::SEQ_TB_READ: next_seq = (tally != 10'h000) ? ctl_pkg::SEQ_TB_WRITE :
        ctl_pkg::SEQ_TB_SAVE;
      ctl_pkg::SEQ_IDLE: next_seq = ctl_pkg::SEQ_IDLE;
      default: next_seq = boundary_stop ? ctl_pkg::SEQ_IDLE :
        tb_pending ? ctl_pkg::SEQ_TB_READ : ctl_pkg::SEQ_FETCH;
    endcase
  end

  // Memory request launched on entering a sequence.
  wire launch = (mc_end && next_seq != ctl_pkg::SEQ_IDLE) || (start && !running);
  wire [13:0] next_addr =
    (!running || next_seq == ctl_pkg::SEQ_FETCH) ? preg :
    (next_seq == ctl_pkg::SEQ_OPREAD) ? mdr[13:0] :
    (next_seq == ctl_pkg::SEQ_OPWRITE) ? z[13:0] :
    (next_seq == ctl_pkg::SEQ_TB_SAVE) ? ctl_pkg::TB_SAVE_ADDR : ctl_pkg::TB_CTRL_ADDR;
  wire [23:0] next_wdata =
    (next_seq == ctl_pkg::SEQ_OPWRITE) ? acm_sum :
    (next_seq == ctl_pkg::SEQ_TB_WRITE) ? {tally - 10'h001, mdr[13:0]} :
    {10'h000, preg};
  wire next_we = running && (next_seq == ctl_pkg::SEQ_OPWRITE ||
    next_seq == ctl_pkg::SEQ_TB_WRITE || next_seq == ctl_pkg::SEQ_TB_SAVE);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= (bus_req && !wb_ack_o) ? rd_mux : wb_dat_o;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode <= ctl_pkg::MODE_RUN;
      halt_byp <= 1'b0;
      horn_dis <= 1'b0;
    end else if (wr_ctrl) begin
      mode <= wb_dat_i[1:0];
      halt_byp <= wb_dat_i[ctl_pkg::CTRL_HALT_BYP];
      horn_dis <= wb_dat_i[ctl_pkg::CTRL_HORN_DIS];
    end
  end

  // Phase and clock-cycle counters of the timing chain.
  always_ff @(posedge core_clk) begin
    if (!rstn || mclr || !running) begin
      div_cnt <= 32'h00000000;
      ph <= 2'h0;
      ccyc <= 3'h0;
      phase <= 4'h1;
    end else begin
      div_cnt <= div_tick ? 32'h00000000 : div_cnt + 32'h00000001;
      if (ph_adv) begin
        ph <= ph + 2'h1;
        phase <= {phase[2:0], phase[3]};
        if (ph == 2'(ctl_pkg::PHASES - 1)) begin
          ccyc <= last_ph ? 3'h0 : ccyc + 3'h1;
        end
      end
    end
  end

  // Sequencer, run control and memory handshake.
  always_ff @(posedge core_clk) begin
    if (!rstn || mclr) begin
      seq <= ctl_pkg::SEQ_IDLE;
      running <= 1'b0;
      stop_req <= 1'b0;
      mem_valid <= 1'b0;
      mem_req <= '0;
      mdr <= 24'h000000;
    end else begin
      if (mem_valid && mem_ack) begin
        mem_valid <= 1'b0;
        mdr <= mem_rdata;
      end
      if (launch) begin
        mem_valid <= 1'b1;
        mem_req <= '{we: next_we, addr: next_addr, wdata: next_wdata};
      end
      stop_req <= running && !at_boundary && (stop_req || stop);
      if (start && !running) begin
        running <= 1'b1;
        seq <= ctl_pkg::SEQ_FETCH;
      end else if (mc_end) begin
        seq <= next_seq;
        running <= next_seq != ctl_pkg::SEQ_IDLE;
      end
    end
  end

  // Architectural registers.
  always_ff @(posedge core_clk) begin
    if (!rstn || mclr) begin
      acc <= 24'h000000;
      breg <= 14'h0000;
      preg <= 14'h0000;
      z <= 24'h000000;
      opcode <= 5'h00;
    end else if (wr_p) begin
      preg <= wb_dat_i[13:0];
    end else if (mc_end) begin
      if (seq == ctl_pkg::SEQ_FETCH) begin
        z <= mdr;
        opcode <= op_new;
        preg <= preg + 14'h0001;
      end
      if (seq == ctl_pkg::SEQ_TB_READ && tally == 10'h000) begin
        preg <= mdr[13:0];
      end
      if (seq == ctl_pkg::SEQ_EXEC && opcode == ctl_pkg::OP_COMPL) begin
        acc <= ~acc;
      end
      if (seq == ctl_pkg::SEQ_EXEC && opcode == ctl_pkg::OP_ADDB) begin
        acc <= addb_sum;
        breg <= addb_sum[13:0];
      end
    end
  end

  // Fault lamp and horn on halt, with or without the bypass.
  always_ff @(posedge core_clk) begin
    if (!rstn || mclr) begin
      fault_lamp <= 1'b0;
      horn <= 1'b0;
    end else if (mc_end && ex_halt) begin
      fault_lamp <= 1'b1;
      horn <= !horn_dis;
    end else if (horn_dis) begin
      horn <= 1'b0;
    end
  end

  // External function output to the peripheral controllers.
  always_ff @(posedge core_clk) begin
    if (!rstn || mclr) begin
      ext_fn_valid <= 1'b0;
      ext_fn <= '0;
    end else begin
      ext_fn_valid <= mc_end && ext_fn_send;
      if (mc_end && ext_fn_send) begin
        ext_fn <= '{unit: ext_fn_unit, code: ext_fn_code};
      end
    end
  end

  // Printer data request is a pin from another domain.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prn_s1 <= 1'b0;
      prn_s2 <= 1'b0;
      prn_pending <= 1'b0;
    end else begin
      prn_s1 <= prn_data_req;
      prn_s2 <= prn_s1;
      prn_pending <= prn_s2 || (prn_pending && !(mc_end && ext_fn_send && prn_desel));
    end
  end

  // Time-base armed flag, millisecond timer and pending request.
  always_ff @(posedge core_clk) begin
    if (!rstn || mclr) begin
      tb_armed <= 1'b0;
      tb_cnt <= 32'h00000000;
      tb_pending <= 1'b0;
      other_grant <= 1'b0;
    end else begin
      if (mc_end && ex_ext_fn && tb_arm) begin
        tb_armed <= 1'b1;
      end else if (mc_end && ((ex_ext_fn && tb_disarm) ||
          (seq == ctl_pkg::SEQ_TB_READ && tally == 10'h000))) begin
        tb_armed <= 1'b0;
      end
      tb_cnt <= (!tb_armed || tb_hit) ? 32'h00000000 : tb_cnt + 32'h00000001;
      if (tb_armed && tb_hit) begin
        tb_pending <= 1'b1;
      end else if (mc_end && next_seq == ctl_pkg::SEQ_TB_READ) begin
        tb_pending <= 1'b0;
      end
      other_grant <= at_boundary && other_req && !tb_pending && !boundary_stop;
    end
  end
endmodule // control_exec
`default_nettype wire

// ### hw/ctl_pkg.sv
// Purpose: Shared constants and carrier types for the control-section sequencer.
// Assumes: Core clock of 250 MHz and 24-bit machine words.
// Notes: Register offsets are byte addresses on a classic Wishbone slave.
package ctl_pkg;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned PHASE_NS = 167;
  localparam int unsigned PHASE_CYC = (PHASE_NS / CLK_NS > 0) ? PHASE_NS / CLK_NS : 1;
  localparam int unsigned PHASES = 4;
  localparam int unsigned CLK_CYCLES_PER_MEM = 6;
  localparam int unsigned TB_PERIOD_NS = 1000000;
  localparam int unsigned TB_PERIOD_CYC = TB_PERIOD_NS / CLK_NS;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned TALLY_LSB = 14;
  localparam logic [13:0] TB_CTRL_ADDR = 14'h002A;
  localparam logic [13:0] TB_SAVE_ADDR = 14'h002B;
  localparam logic [4:0] OP_HALT0 = 5'h00;
  localparam logic [4:0] OP_COMPL = 5'h01;
  localparam logic [4:0] OP_EXT_FN = 5'h07;
  localparam logic [4:0] OP_HALT1 = 5'h09;
  localparam logic [4:0] OP_ACM = 5'h11;
  localparam logic [4:0] OP_ADDB = 5'h1E;
  localparam logic [4:0] OP_STOP = 5'h1F;
  localparam logic [4:0] UNIT_TBI = 5'h07;
  localparam logic [4:0] UNIT_PRN = 5'h03;
  localparam logic [7:0] PRN_DESELECT = 8'h50;
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_SINGLE_INSTRUCTION_STEP = 2'h1;
  localparam logic [1:0] MODE_PHASE_STEP = 2'h2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_BREG = 8'h0C;
  localparam logic [7:0] REG_PREG = 8'h10;
  localparam int unsigned CTRL_HALT_BYP = 2;
  localparam int unsigned CTRL_HORN_DIS = 3;
  localparam int unsigned CTRL_MCLR = 8;
  localparam int unsigned CTRL_START = 9;
  localparam int unsigned CTRL_STOP = 10;
  localparam int unsigned CTRL_STEP = 11;

  typedef enum {SEQ_IDLE, SEQ_FETCH, SEQ_EXEC, SEQ_OPREAD, SEQ_OPWRITE,
    SEQ_TB_READ, SEQ_TB_WRITE, SEQ_TB_SAVE} seq_t;

  typedef struct packed {
    logic [4:0] unit;
    logic [10:0] code;
  } ext_fn_t;

  typedef struct packed {
    logic we;
    logic [13:0] addr;
    logic [23:0] wdata;
  } mem_req_t;
endpackage

// ### bench/control_exec_monitor.sv
// Purpose: Port-level checks for the control section.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound into every instance of control_exec.
`timescale 1ns/10ps
`default_nettype none
module control_exec_monitor #(
  parameter int unsigned PHASE_DIV = 1
) (
  input wire logic core_clk, // Core clock.
  input wire logic rstn, // Reset, active low.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Bus write.
  input wire logic [7:0] wb_adr_i, // Bus address.
  input wire logic [3:0] wb_sel_i, // Bus lanes.
  input wire logic [31:0] wb_dat_i, // Bus write data.
  input wire logic [31:0] wb_dat_o, // Bus read data.
  input wire logic wb_ack_o, // Bus acknowledge.
  input wire ctl_pkg::mem_req_t mem_req, // Memory request.
  input wire logic mem_valid, // Memory valid.
  input wire logic mem_ack, // Memory answer.
  input wire logic [23:0] mem_rdata, // Memory data.
  input wire ctl_pkg::ext_fn_t ext_fn, // External function.
  input wire logic ext_fn_valid, // Function strobe.
  input wire logic prn_data_req, // Printer request.
  input wire logic other_req, // Other request.
  input wire logic other_grant, // Other grant.
  input wire logic [3:0] phase, // Clock phase.
  input wire logic fault_lamp, // Fault lamp.
  input wire logic horn, // Horn.
  input wire logic tb_armed // Time base armed.
);
  logic [11:0] gap;
  logic prn_seen;
  wire desel = ext_fn_valid && ext_fn.unit == ctl_pkg::UNIT_PRN &&
    ext_fn.code[7:0] == ctl_pkg::PRN_DESELECT;
  // Gap counts edges since the last memory request was launched.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gap <= 12'hFFF;
      prn_seen <= 1'b0;
    end else begin
      gap <= $rose(mem_valid) ? 12'h001 : gap + {11'h000, gap != 12'hFFF};
      prn_seen <= prn_data_req || (prn_seen && !desel);
    end
  end
  default clocking mcb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  a_phase_onehot: assert property ($onehot(phase))
    else $error("phase not one-hot");
  a_phase_rotate: assert property (!$stable(phase) |-> phase == {$past(phase[2:0]), $past(phase[3])})
    else $error("phase out of order");
  a_mem_hold: assert property (mem_valid && !mem_ack |=> mem_valid && $stable(mem_req))
    else $error("memory request dropped");
  a_mem_spacing: assert property ($rose(mem_valid) |-> gap >= 24 * PHASE_DIV)
    else $error("memory cycle too short");
  a_fn_pulse: assert property (ext_fn_valid |=> !ext_fn_valid)
    else $error("function strobe too long");
  a_tb_not_sent: assert property (ext_fn_valid |-> ext_fn.unit != ctl_pkg::UNIT_TBI)
    else $error("time base code sent out");
  a_deselect_gated: assert property (desel |-> prn_seen)
    else $error("deselect without request");
  a_horn_fault: assert property (horn |-> fault_lamp)
    else $error("horn without fault");
  a_grant_single: assert property (other_grant |=> !other_grant)
    else $error("grant too long");
endmodule // control_exec_monitor
bind control_exec control_exec_monitor #(.PHASE_DIV(PHASE_DIV)) control_exec_monitor_inst (.*);
`default_nettype wire

// ### bench/mem_model.sv
// Purpose: Memory and peripheral-controller stand-in for the control section.
// Assumes: 64 words, address aliased on the low six bits.
// Notes: Answers alternately at once and three cycles late.
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  input wire logic core_clk, // Core clock.
  input wire ctl_pkg::mem_req_t mem_req, // Memory request.
  input wire logic mem_valid, // Request valid.
  output logic mem_ack, // Answer strobe.
  output logic [23:0] mem_rdata, // Read data.
  input wire ctl_pkg::ext_fn_t ext_fn, // External function.
  input wire logic ext_fn_valid // Function strobe.
);
  logic [23:0] mem [64];
  logic [1:0] wait_cnt;
  logic done;
  logic slow;
  int ext_fn_count;
  ctl_pkg::ext_fn_t ext_fn_last;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 24'h000000;
    wait_cnt = 2'h0;
    done = 1'b0;
    slow = 1'b0;
    ext_fn_count = 0;
  end
  // Read data flips every cycle outside the answer so stale data never matches.
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (ext_fn_valid) begin
      ext_fn_count <= ext_fn_count + 1;
      ext_fn_last <= ext_fn;
    end
    if (!mem_valid) begin
      done <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (!done && wait_cnt == {slow, slow}) begin
      mem_ack <= 1'b1;
      done <= 1'b1;
      slow <= ~slow;
      if (mem_req.we) mem[mem_req.addr[5:0]] <= mem_req.wdata;
      else mem_rdata <= mem[mem_req.addr[5:0]];
    end else if (!done) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule // mem_model
`default_nettype wire

// ### bench/test_control_exec.sv
// Purpose: Self-checking bench for the control section.
// Assumes: One phase per clock and a 200-clock time base.
// Notes: Program runs from the memory model, results read over the bus and from the memory model.
`timescale 1ns/10ps
`default_nettype none
module test_control_exec;
  logic core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_valid, mem_ack;
  logic ext_fn_valid, prn_data_req, other_req, other_grant, fault_lamp, horn, tb_armed;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [3:0] phase;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [23:0] mem_rdata;
  logic [23:0] prog [6];
  ctl_pkg::mem_req_t mem_req;
  ctl_pkg::ext_fn_t ext_fn;
  int failures, compares, cycles, grants;
  control_exec #(.TB_PERIOD(200), .PHASE_DIV(1)) control_exec_inst (.*);
  mem_model mem_model_inst (.*);
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) failures++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_stop();
    int n;
    n = 0;
    do begin
      repeat (20) @(posedge core_clk);
      wb_cycle(1'b0, ctl_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (other_grant === 1'b1) grants++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, prn_data_req, other_req} = 6'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    {failures, compares, cycles} = {32'h0, 32'h0, 32'h0};
    grants = 0;
    prog = '{24'h080000, 24'h39C0C0, 24'hF00000, 24'h894030, 24'h38C050, 24'h384095};
    for (int i = 0; i < 64; i++) mem_model_inst.mem[i] = i < 6 ? prog[i] : 24'h100000;
    mem_model_inst.mem[32] = 24'h480000;
    mem_model_inst.mem[33] = 24'hF80000;
    mem_model_inst.mem[34] = 24'h000000;
    mem_model_inst.mem[35] = 24'h38C050;
    mem_model_inst.mem[48] = 24'h000007;
    mem_model_inst.mem[42] = 24'h004020;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    wb_cycle(1'b0, ctl_pkg::REG_STATUS, 32'h0);
    check("status_reset", rd, 32'h0);
    wb_cycle(1'b1, 8'h20, 32'hFFFF);
    wb_cycle(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    wb_cycle(1'b1, ctl_pkg::REG_CTRL, 32'h200);
    wait_stop();
    check("halt_status", rd, 32'h24C);
    wb_cycle(1'b0, ctl_pkg::REG_ACC, 32'h0);
    check("acc", rd, 32'hFFFFFF);
    wb_cycle(1'b0, ctl_pkg::REG_BREG, 32'h0);
    check("breg", rd, 32'h3FFF);
    wb_cycle(1'b0, ctl_pkg::REG_PREG, 32'h0);
    check("preg", rd, 32'h21);
    check("acm", mem_model_inst.mem[48], 32'hC);
    check("tally", mem_model_inst.mem[42], 32'h20);
    check("save_top", mem_model_inst.mem[43][23:14], 32'h0);
    check("fn_count", mem_model_inst.ext_fn_count, 32'h1);
    check("fn_last", mem_model_inst.ext_fn_last, 32'h0895);
    wb_cycle(1'b1, ctl_pkg::REG_CTRL, 32'h100);
    wb_cycle(1'b0, ctl_pkg::REG_ACC, 32'h0);
    check("acc_clear", rd, 32'h0);
    wb_cycle(1'b1, ctl_pkg::REG_PREG, 32'h21);
    other_req <= 1'b1;
    prn_data_req <= 1'b1;
    wb_cycle(1'b1, ctl_pkg::REG_CTRL, 32'h20C);
    repeat (300) @(posedge core_clk);
    wb_cycle(1'b0, ctl_pkg::REG_STATUS, 32'h0);
    check("bypass_run", rd & 32'hF, 32'h5);
    check("desel_count", mem_model_inst.ext_fn_count, 32'h2);
    check("desel_last", mem_model_inst.ext_fn_last, 32'h1850);
    check("grant_seen", grants != 0, 32'h1);
    wb_cycle(1'b0, ctl_pkg::REG_CTRL, 32'h0);
    check("ctrl_bits", rd & 32'hF, 32'hC);
    wb_cycle(1'b1, ctl_pkg::REG_CTRL, 32'h40C);
    wait_stop();
    check("stopped", rd & 32'h1, 32'h0);
    wb_cycle(1'b1, ctl_pkg::REG_PREG, 32'h24);
    wb_cycle(1'b1, ctl_pkg::REG_CTRL, 32'h201);
    wait_stop();
    wb_cycle(1'b0, ctl_pkg::REG_PREG, 32'h0);
    check("single_instruction_step", rd, 32'h25);
    summarize();
  end
endmodule // test_control_exec
`default_nettype wire
